/* File: rtl/vcm_pkg.sv */
// Constants shared by the video clock multiplier configuration block.
// Assumes a 32-bit AXI4-Lite register bus and a single 100 MHz clock.
package vcm_pkg;

  // Clock rate of the register and sampling clock.
  localparam int CLK_HZ = 100_000_000;

  // Widths of the three divider codes and of the serial word.
  localparam int PRE_W = 2;
  localparam int OUT_W = 7;
  localparam int FB_W = 5;
  localparam int WORD_W = PRE_W + OUT_W + FB_W;

  // Serial word layout, shifted in most significant bit first.
  localparam int FB_LSB = 0;
  localparam int OUT_LSB = FB_LSB + FB_W;
  localparam int PRE_LSB = OUT_LSB + OUT_W;

  // Settings after reset: pre-divide 1, output divide 10, feedback 12.
  localparam logic [PRE_W-1:0] PRE_RST = 2'h0;
  localparam logic [OUT_W-1:0] OUT_RST = 7'h05;
  localparam logic [FB_W-1:0] FB_RST = 5'h0C;

  // Feedback divide range.
  localparam logic [FB_W-1:0] FB_MIN = 5'h05;
  localparam logic [FB_W-1:0] FB_MAX = 5'h1C;

  // Register byte offsets.
  localparam logic [7:0] SETTINGS_OFS = 8'h00;
  localparam logic [7:0] SHIFT_OFS = 8'h04;
  localparam logic [7:0] FLOAT_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0C;

  // Bit positions of the unconnected-pin mask (and of the pin levels
  // shown in the status register).
  localparam int PIN_DATA = 0;
  localparam int PIN_SCLK = 1;
  localparam int PIN_LOAD = 2;
  localparam int PIN_BYP = 3;
  localparam int PIN_RSEL = 4;
  localparam int PIN_N = 5;
  localparam logic [PIN_N-1:0] FLOAT_RST = 5'h00;
  // Level that an unconnected pin reads through its internal resistor.
  localparam logic [PIN_N-1:0] PIN_DEFAULT = 5'h10;

  // Status register fields.
  localparam int ST_LATCHED = 8;
  localparam int ST_FB_RANGE = 9;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : vcm_pkg

/* File: rtl/vcm_clock_config.sv */
// Serial divider programming, reference and bypass selection and the
// digital dividers of a video clock multiplier, with an AXI4-Lite slave.
// Assumes all pins are synchronous to aclk and that the analog PLL
// supplies one vco_tick pulse per VCO period in scaled time.
//
// Added by the designer: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps

// What this block does
// - With load low, each rising shift clock shifts the data bit in.
// - A rising load edge copies the shift register into the settings.
// - A falling load edge latches the settings, which then hold.
// - With load high, each rising shift clock shifts data into the settings.
// - Reference select low picks the single-ended input, high the pair.
// - Bypass low feeds the output divider from the PLL, high from the reference.
// - The output clock is the source divided with a 50% duty cycle.
// - The feedback divider output goes to the phase detector.
// - The VCO runs at reference times feedback over pre.
// - Unconnected inputs read low except reference select, which reads high.
// - The pre-divide code 0..3 selects divide by 1, 2, 4 or 8.
// - The output divide code is half the output divide ratio.
// - The feedback divide code is the ratio itself, from 5 to 28.
module vcm_clock_config
  import vcm_pkg::*;
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Serial programming pins.
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic ser_load,
  // Static selection pins.
  input wire logic ref_sel,
  input wire logic bypass,
  // Reference clocks and VCO events.
  input wire logic single_ended_ref,
  input wire logic ref_pos,
  input wire logic ref_neg,
  input wire logic vco_tick,
  // Clock outputs, phase detector events and the active settings.
  output logic clk_out,
  output logic feedback_output,
  output logic pd_ref_pulse,
  output logic pd_fb_pulse,
  output logic [WORD_W-1:0] settings,
  // AXI4-Lite write channels.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels.
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  logic [PIN_N-1:0] float_mask;
  logic [WORD_W-1:0] shift_reg;
  logic latched;
  logic sclk_q;
  logic load_q;
  logic ref_q;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [OUT_W-1:0] out_cnt;
  logic [FB_W-1:0] fb_cnt;
  logic [2:0] pre_cnt;

  // Unconnected pins read their resistor default.
  wire [PIN_N-1:0] pin_raw = {ref_sel, bypass, ser_load, ser_clk, ser_data};
  wire [PIN_N-1:0] pin_eff = (pin_raw & ~float_mask)
                           | (PIN_DEFAULT & float_mask);
  wire data_eff = pin_eff[PIN_DATA];
  wire sclk_eff = pin_eff[PIN_SCLK];
  wire load_eff = pin_eff[PIN_LOAD];
  wire byp_eff = pin_eff[PIN_BYP];
  wire rsel_eff = pin_eff[PIN_RSEL];

  wire sclk_rise = sclk_eff & ~sclk_q;
  wire load_rise = load_eff & ~load_q;
  wire load_fall = ~load_eff & load_q;

  wire [PRE_W-1:0] pre_code = settings[PRE_LSB +: PRE_W];
  wire [OUT_W-1:0] out_code = settings[OUT_LSB +: OUT_W];
  wire [FB_W-1:0] fb_code = settings[FB_LSB +: FB_W];

  // Pre-divide ratio is two to the power of the code.
  wire [3:0] pre_ratio = 4'h1 << pre_code;
  // A zero code would stall a divider, so it acts as the smallest ratio.
  wire [OUT_W-1:0] out_half = (out_code == 7'h00) ? 7'h01 : out_code;
  wire [FB_W-1:0] fb_ratio = (fb_code == 5'h00) ? 5'h01 : fb_code;
  wire feedback_input_range = (fb_code >= FB_MIN) && (fb_code <= FB_MAX);

  // Reference selection and the divider source.
  wire ref_sel_clk = rsel_eff ? (ref_pos & ~ref_neg)
                              : single_ended_ref;
  wire ref_rise = ref_sel_clk & ~ref_q;
  wire src_tick = byp_eff ? ref_rise : vco_tick;

  wire out_wrap = src_tick && (out_cnt >= out_half - 7'h01);
  wire fb_wrap = vco_tick && (fb_cnt >= fb_ratio - 5'h01);
  wire pre_wrap = ref_rise && ({1'b0, pre_cnt} >= pre_ratio - 4'h1);

  wire [WORD_W-1:0] next_shift = {shift_reg[WORD_W-2:0], data_eff};
  wire [WORD_W-1:0] next_settings = {settings[WORD_W-2:0], data_eff};

  // Register bus decode.
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire wr_go = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  wire wr_float = aw_addr == FLOAT_OFS;
  wire wr_known = wr_float || (aw_addr == SETTINGS_OFS)
                || (aw_addr == SHIFT_OFS) || (aw_addr == STATUS_OFS);
  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire rd_known = (s_axi_araddr == SETTINGS_OFS)
                || (s_axi_araddr == SHIFT_OFS)
                || (s_axi_araddr == FLOAT_OFS)
                || (s_axi_araddr == STATUS_OFS);
  wire [31:0] status_word = {22'h0, feedback_input_range, latched,
                             3'h0, pin_eff};
  wire [31:0] rd_word = (s_axi_araddr == SETTINGS_OFS) ? 32'(settings)
                      : (s_axi_araddr == SHIFT_OFS) ? 32'(shift_reg)
                      : (s_axi_araddr == FLOAT_OFS) ? 32'(float_mask)
                      : (s_axi_araddr == STATUS_OFS) ? status_word
                      : 32'h0;

  // Edge history of the pins and the selected reference.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sclk_q <= 1'b0;
      load_q <= 1'b0;
      ref_q <= 1'b0;
    end
    else
    begin
      sclk_q <= sclk_eff;
      load_q <= load_eff;
      ref_q <= ref_sel_clk;
    end
  end

  // Serial shift register, only moving while load is low.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      shift_reg <= {PRE_RST, OUT_RST, FB_RST};
    else if (sclk_rise && !load_eff)
      shift_reg <= next_shift;
  end

  // Active divider settings.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      settings <= {PRE_RST, OUT_RST, FB_RST};
    else if (load_rise)
      settings <= shift_reg;
    else if (load_eff && sclk_rise)
      settings <= next_settings;
  end

  // Latched flag: set by a falling load, cleared by a new load rise.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      latched <= 1'b0;
    else if (load_fall)
      latched <= 1'b1;
    else if (load_rise)
      latched <= 1'b0;
  end

  // Output divider: toggles every out_half source events.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      out_cnt <= 7'h00;
      clk_out <= 1'b0;
      feedback_output <= 1'b0;
    end
    else if (out_wrap)
    begin
      out_cnt <= 7'h00;
      clk_out <= ~clk_out;
      feedback_output <= ~clk_out;
    end
    else if (src_tick)
      out_cnt <= out_cnt + 7'h01;
  end

  // Feedback and pre-dividers feeding the phase detector.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fb_cnt <= 5'h00;
      pre_cnt <= 3'h0;
      pd_fb_pulse <= 1'b0;
      pd_ref_pulse <= 1'b0;
    end
    else
    begin
      pd_fb_pulse <= fb_wrap;
      pd_ref_pulse <= pre_wrap;
      if (fb_wrap)
        fb_cnt <= 5'h00;
      else if (vco_tick)
        fb_cnt <= fb_cnt + 5'h01;
      if (pre_wrap)
        pre_cnt <= 3'h0;
      else if (ref_rise)
        pre_cnt <= pre_cnt + 3'h1;
    end
  end

  // Write channels: address and data taken in either order.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      aw_addr <= 8'h00;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      float_mask <= FLOAT_RST;
    end
    else
    begin
      if (aw_take)
      begin
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (w_take)
      begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      else if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
        if (wr_float && w_strb[0])
          float_mask <= w_data[PIN_N-1:0];
      end
    end
  end

  // Read channels.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (ar_take)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_shift_serial_in: assert property (
    sclk_rise && !load_eff |=> shift_reg == $past(next_shift))
    else $error("shift register missed a serial bit");

  a_load_transfer: assert property (
    load_rise |=> settings == $past(shift_reg))
    else $error("settings not loaded on load rise");

  a_latched_hold: assert property (
    !load_eff && !load_q |=> $stable(settings))
    else $error("settings changed while latched");

  a_transparent_shift: assert property (
    load_eff && load_q && sclk_rise
      |=> settings == {$past(settings[WORD_W-2:0]), $past(data_eff)})
    else $error("transparent mode did not pass data");

  a_ref_select: assert property (
    !rsel_eff |-> ref_sel_clk == single_ended_ref)
    else $error("wrong reference source selected");

  a_bypass_source: assert property (
    byp_eff && $stable(out_code) && ref_rise && !out_wrap
      |=> out_cnt == $past(out_cnt) + 7'h01)
    else $error("bypass did not route the reference");

  a_out_half_period: assert property (
    src_tick && out_cnt == out_half - 7'h01 |=> clk_out != $past(clk_out))
    else $error("output divider half period wrong");

  a_fb_pulse: assert property (
    fb_wrap |=> pd_fb_pulse && fb_cnt == 5'h00)
    else $error("feedback pulse missing");

  a_float_default: assert property (
    float_mask[PIN_RSEL] |-> rsel_eff)
    else $error("floating reference select not high");

  a_pre_ratio: assert property (
    ref_rise && {1'b0, pre_cnt} + 4'h1 < 4'h1 << pre_code |=> !pd_ref_pulse)
    else $error("pre-divide pulse came early");

endmodule : vcm_clock_config

/* File: bench/vcm_ser_ctrl.sv */
// Model of the external controller on the three-wire programming port.
// Assumes the block samples the pins on aclk; idle lines sit low.
`timescale 1ns/1ps
module vcm_ser_ctrl
  import vcm_pkg::*;
(
  // Clock.
  input wire logic aclk,
  // Programming pins.
  output logic ser_clk,
  output logic ser_data,
  output logic ser_load
);
  initial
  begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    ser_load = 1'b0;
  end

  // Sends a word most significant bit first, data set while clock is low.
  task automatic send(input logic [WORD_W-1:0] w);
    for (int i = WORD_W - 1; i >= 0; i--)
    begin
      @(posedge aclk);
      ser_data <= w[i];
      ser_clk <= 1'b0;
      @(posedge aclk);
      ser_clk <= 1'b1;
    end
    @(posedge aclk);
    ser_clk <= 1'b0;
    ser_data <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask : send

  task automatic load(input logic v);
    @(posedge aclk);
    ser_load <= v;
    repeat (3) @(posedge aclk);
  endtask : load
endmodule : vcm_ser_ctrl

/* File: bench/test_video_clock_multiplier_serial_config.sv */
// Self-checking bench for the clock configuration block.
// Assumes the controller model drives the programming pins.
`timescale 1ns/1ps
module test_video_clock_multiplier_serial_config
  import vcm_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ref_sel = 1'b0, bypass = 1'b1, single_ended_ref = 1'b0;
  logic ref_pos = 1'b0, ref_neg = 1'b1, vco_tick = 1'b0, co_q = 1'b0;
  logic ser_clk, ser_data, ser_load;
  logic clk_out, feedback_output, pd_ref_pulse, pd_fb_pulse;
  logic [WORD_W-1:0] settings, w1, w2;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  int err_total = 0, checked = 0, evn = 0;
  int t_last, t_gap, r_last, r_gap, f_last, f_gap;

  always #5 aclk = ~aclk;

  vcm_clock_config u_vcm_clock_config (.aclk(aclk), .aresetn(aresetn),
    .ser_clk(ser_clk), .ser_data(ser_data), .ser_load(ser_load),
    .ref_sel(ref_sel), .bypass(bypass), .single_ended_ref(single_ended_ref),
    .ref_pos(ref_pos), .ref_neg(ref_neg), .vco_tick(vco_tick),
    .clk_out(clk_out), .feedback_output(feedback_output),
    .pd_ref_pulse(pd_ref_pulse), .pd_fb_pulse(pd_fb_pulse),
    .settings(settings), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));

  vcm_ser_ctrl u_vcm_ser_ctrl (.aclk(aclk), .ser_clk(ser_clk),
    .ser_data(ser_data), .ser_load(ser_load));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: %s %h not %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : stop_test

  task automatic guard(input int n);
    if (n >= 40)
    begin
      err_total++;
      $display("mismatch at %0t: bus wait ran out", $time);
      stop_test();
    end
  endtask : guard

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    int n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1 && n < 40);
    bready <= 1'b0;
    guard(n);
    check(32'(bresp), 32'(er), "bresp");
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] e, input logic [1:0] er);
    int n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (arready)
        arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1 && n < 40);
    rready <= 1'b0;
    guard(n);
    check(32'(rresp), 32'(er), "rresp");
    check(rdata & m, e, "rdata");
  endtask : rd

  // Records how many source events lie between divider outputs.
  always @(posedge aclk)
  begin
    if (clk_out !== co_q)
    begin
      t_gap = evn - t_last;
      t_last = evn;
    end
    co_q = clk_out;
    if (pd_ref_pulse === 1'b1)
    begin
      r_gap = evn - r_last;
      r_last = evn;
    end
    if (pd_fb_pulse === 1'b1)
    begin
      f_gap = evn - f_last;
      f_last = evn;
    end
  end

  // Kind 0 pulses the single-ended input, 1 the pair, 2 the VCO tick.
  task automatic run(input int kind);
    t_gap = 0;
    r_gap = 0;
    f_gap = 0;
    ref_sel <= (kind == 1);
    bypass <= (kind != 2);
    repeat (20)
    begin
      @(posedge aclk);
      single_ended_ref <= (kind == 0);
      ref_pos <= (kind == 1);
      ref_neg <= (kind != 1);
      vco_tick <= (kind == 2);
      @(posedge aclk);
      evn++;
      single_ended_ref <= 1'b0;
      ref_pos <= 1'b0;
      ref_neg <= 1'b1;
      vco_tick <= 1'b0;
      repeat (2) @(posedge aclk);
    end
  endtask : run

  initial
  begin
    void'($urandom(32'h764A3044));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(SETTINGS_OFS, 32'hFFFFFFFF, 32'h000000AC, RESP_OKAY);
    rd(SHIFT_OFS, 32'hFFFFFFFF, 32'h000000AC, RESP_OKAY);
    rd(FLOAT_OFS, 32'hFFFFFFFF, 32'h0, RESP_OKAY);
    wr(8'h10, 32'h1, RESP_SLVERR);
    rd(8'h10, 32'hFFFFFFFF, 32'h0, RESP_SLVERR);
    // A write without byte lane 0 must leave the mask alone.
    wstrb <= 4'($urandom) & 4'hE;
    wr(FLOAT_OFS, 32'h1F, RESP_OKAY);
    rd(FLOAT_OFS, 32'hFFFFFFFF, 32'h0, RESP_OKAY);
    wstrb <= 4'($urandom) | 4'h1;
    wr(FLOAT_OFS, 32'h1F, RESP_OKAY);
    rd(STATUS_OFS, 32'h1F, 32'(PIN_DEFAULT), RESP_OKAY);
    wr(FLOAT_OFS, 32'h0, RESP_OKAY);
    rd(STATUS_OFS, 32'h1F, 32'h08, RESP_OKAY);
    wr(SETTINGS_OFS, 32'h3FFF, RESP_OKAY);
    check(32'(settings), 32'h00AC, "settings");
    w1 = {2'($urandom_range(3)), 7'($urandom_range(127, 1)),
          5'($urandom_range(28, 5))};
    w2 = {2'($urandom_range(3)), 7'($urandom_range(127, 1)), 5'h03};
    u_vcm_ser_ctrl.send(w1);
    check(32'(settings), 32'h00AC, "shift only");
    rd(SHIFT_OFS, 32'h3FFF, 32'(w1), RESP_OKAY);
    u_vcm_ser_ctrl.load(1'b1);
    check(32'(settings), 32'(w1), "load rise");
    rd(STATUS_OFS, 32'h300, 32'h200, RESP_OKAY);
    u_vcm_ser_ctrl.load(1'b0);
    rd(STATUS_OFS, 32'h100, 32'h100, RESP_OKAY);
    u_vcm_ser_ctrl.send(~w1);
    check(32'(settings), 32'(w1), "latched");
    u_vcm_ser_ctrl.load(1'b1);
    u_vcm_ser_ctrl.send(w2);
    check(32'(settings), 32'(w2), "transparent");
    rd(SHIFT_OFS, 32'h3FFF, {18'h0, ~w1}, RESP_OKAY);
    rd(STATUS_OFS, 32'h200, 32'h0, RESP_OKAY);
    u_vcm_ser_ctrl.load(1'b0);
    u_vcm_ser_ctrl.send({2'h1, 7'h03, 5'h05});
    u_vcm_ser_ctrl.load(1'b1);
    u_vcm_ser_ctrl.load(1'b0);
    run(0);
    check(t_gap, 3, "bypass divide");
    check(r_gap, 2, "pre-divide");
    run(1);
    check(t_gap, 3, "pair reference");
    run(2);
    check(t_gap, 3, "vco divide");
    check(f_gap, 5, "feedback divide");
    check(32'(feedback_output), 32'(clk_out), "feedback copy");
    stop_test();
  end
endmodule : test_video_clock_multiplier_serial_config
